// ==== src/spm_pkg.sv ====
/*
 package for the stand-by exit and power mode sequencer: mode codes,
 state enumeration and timing counts. assumes a 125 MHz system clock.
*/
package spm_pkg;

    localparam int unsigned CLK_PERIOD_PS   = 8000;
    // settle time of the ram supply switch before the interface may thaw
    localparam int unsigned SWITCH_TIME_NS  = 1000;
    localparam int unsigned SWITCH_CYCLES   =
        ((SWITCH_TIME_NS * 1000) + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned SWITCH_CNT_W    = 8;

    // requested power mode codes
    localparam logic [1:0] MODE_RUN         = 2'h0;
    localparam logic [1:0] MODE_IDLE        = 2'h1;
    localparam logic [1:0] MODE_PWRDN       = 2'h2;
    localparam logic [1:0] MODE_STBY        = 2'h3;

    // reset values and ram supply select codes
    localparam logic       RAM_EN_RESET     = 1'b0;
    localparam logic       RAM_SEL_STBY     = 1'b0;
    localparam logic       RAM_SEL_MAIN     = 1'b1;

    typedef enum logic [2:0] {
        SPM_HOLD,
        SPM_SWITCH,
        SPM_INIT,
        SPM_RUN,
        SPM_IDLE,
        SPM_PWRDN,
        SPM_STBY
    } spm_state_t;

endpackage

// ==== src/spm_sync.sv ====
/*
 two flip-flop synchroniser for one level.
 assumes an active low asynchronous reset already aligned to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module spm_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // level
    input  wire logic d,
    output logic      q
);
    logic stage1;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1 <= RESET_VAL;
            q      <= RESET_VAL;
        end else begin
            stage1 <= d;
            q      <= stage1;
        end
    end
endmodule // spm_sync
`default_nettype wire

// ==== src/spm_seq.sv ====
/*
 stand-by exit and power mode sequencer: holds reset from pin and low
 voltage detector, moves the retained ram supply to the main rail, keeps
 the ram frozen until software enables it, and applies run, idle,
 power-down and stand-by gating including the counter reference choice.
 assumes external reset circuitry holds the pin low during supply ramp.
*/
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - stand-by exit uses ordinary power-on sequence
// - detector keeps reset until core supply good
// - reset release switches ram supply, still frozen
// - ram accessible only after software enable
// - stand-by counter runs only on 32 kHz
// - main oscillator reference stops counter in stand-by
// - idle, power-down, stand-by gating as specified
// - freeze holds until enable set after reset
module spm_seq
    import spm_pkg::*;
#(
    parameter int unsigned SWITCH_CNT = SWITCH_CYCLES
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // supply and reset sources
    input  wire logic       reset_input_pin_b,
    input  wire logic       low_voltage_detector_ok,
    input  wire logic       main_core_supply_good,
    // software controls
    input  wire logic       standby_ram_enable_set,
    input  wire logic       standby_ram_enable_clear,
    input  wire logic [1:0] mode_request,
    input  wire logic       mode_wake,
    input  wire logic       rtc_use_32k,
    input  wire logic       osc32k_present,
    // status and gating outputs
    output logic            internal_reset,
    output logic            ram_supply_main,
    output logic            ram_freeze,
    output logic            standby_ram_enable,
    output logic            cpu_clk_en,
    output logic            periph_clk_en,
    output logic            main_osc_en,
    output logic            osc32k_en,
    output logic            rtc_run
);
    logic                    rst_meta;
    logic                    rst_sync_b;
    logic                    pin_b;
    logic                    lvd_ok;
    logic                    main_good;
    spm_state_t              state;
    spm_state_t              next_state;
    logic [SWITCH_CNT_W-1:0] switch_cnt;
    logic [SWITCH_CNT_W-1:0] next_switch_cnt;

    // reset release through two flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta   <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_b <= rst_meta;
        end
    end

    // pin and rails are asynchronous: two flops each
    spm_sync #(.RESET_VAL(1'b0)) u_sync_pin (
        .clk   (clk),
        .rst_b (rst_sync_b),
        .d     (reset_input_pin_b),
        .q     (pin_b)
    );

    spm_sync #(.RESET_VAL(1'b0)) u_sync_lvd (
        .clk   (clk),
        .rst_b (rst_sync_b),
        .d     (low_voltage_detector_ok),
        .q     (lvd_ok)
    );

    spm_sync #(.RESET_VAL(1'b0)) u_sync_main (
        .clk   (clk),
        .rst_b (rst_sync_b),
        .d     (main_core_supply_good),
        .q     (main_good)
    );

    // reset source: pin or detector; loss of main supply also resets
    wire reset_req   = !pin_b || !lvd_ok || !main_good;
    wire supply_lost = !main_good;
    wire switch_done = (switch_cnt >= SWITCH_CNT[SWITCH_CNT_W-1:0] - 8'h01);

    // state decode
    wire st_hold     = (state == SPM_HOLD);
    wire st_switch   = (state == SPM_SWITCH);
    wire st_init     = (state == SPM_INIT);
    wire st_run      = (state == SPM_RUN);
    wire st_idle     = (state == SPM_IDLE);
    wire st_pwrdn    = (state == SPM_PWRDN);
    wire st_stby     = (state == SPM_STBY);
    wire in_low      = st_idle || st_pwrdn || st_stby;

    // sequencing: hold, supply switch, init, run and low power modes
    always_comb begin
        next_state      = state;
        next_switch_cnt = '0;
        unique case (state)
            SPM_HOLD: begin
                if (!reset_req) begin
                    next_state = SPM_SWITCH;
                end
            end
            SPM_SWITCH: begin
                next_switch_cnt = switch_cnt + 8'h01;
                if (switch_done) begin
                    next_state = SPM_INIT;
                end
            end
            SPM_INIT: begin
                if (standby_ram_enable || standby_ram_enable_set) begin
                    next_state = SPM_RUN;
                end
            end
            SPM_RUN: begin
                unique case (mode_request)
                    MODE_IDLE:  next_state = SPM_IDLE;
                    MODE_PWRDN: next_state = SPM_PWRDN;
                    MODE_STBY:  next_state = SPM_STBY;
                    MODE_RUN:   next_state = SPM_RUN;
                endcase
            end
            SPM_IDLE, SPM_PWRDN: begin
                if (mode_wake) begin
                    next_state = SPM_RUN;
                end
            end
            SPM_STBY: begin
                next_state = SPM_STBY; // left only through reset
            end
        endcase
        if (reset_req) begin
            next_state = SPM_HOLD;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            state      <= SPM_HOLD;
            switch_cnt <= '0;
        end else begin
            state      <= next_state;
            switch_cnt <= next_switch_cnt;
        end
    end

    // software enable; set wins over clear, reset forces clear
    wire next_ram_en = reset_req ? RAM_EN_RESET :
                       standby_ram_enable_set ? 1'b1 :
                       standby_ram_enable_clear ? 1'b0 : standby_ram_enable;

    // supply selection: main rail only once reset released
    wire next_ram_main = !st_hold && !reset_req;
    // freeze covers the supply switch whatever the enable says
    wire freeze_seq    = st_hold || st_switch;
    wire next_freeze   = reset_req || freeze_seq || !next_ram_en;

    // counter reference: with the main rail gone only the 32 kHz path survives
    wire use_32k   = rtc_use_32k && osc32k_present;
    wire rtc_keep  = st_stby || st_hold;
    wire next_rtc  = rtc_keep ? use_32k : 1'b1;
    wire next_cpu  = st_run || st_init;
    wire next_per  = next_cpu || st_idle;
    wire mosc_off  = st_stby || (st_pwrdn && use_32k) || (st_hold && supply_lost);
    wire next_mosc = !mosc_off;
    wire next_o32  = use_32k;

    // ram side: reset flag, supply select, freeze and enable
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            internal_reset     <= 1'b1;
            ram_supply_main    <= RAM_SEL_STBY;
            ram_freeze         <= 1'b1;
            standby_ram_enable <= RAM_EN_RESET;
        end else begin
            internal_reset     <= reset_req;
            ram_supply_main    <= next_ram_main;
            ram_freeze         <= next_freeze;
            standby_ram_enable <= next_ram_en;
        end
    end

    // clock gating levels
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            cpu_clk_en    <= 1'b0;
            periph_clk_en <= 1'b0;
            main_osc_en   <= 1'b1;
        end else begin
            cpu_clk_en    <= next_cpu && !in_low;
            periph_clk_en <= next_per;
            main_osc_en   <= next_mosc;
        end
    end

    // low power oscillator and counter
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            osc32k_en <= 1'b0;
            rtc_run   <= 1'b0;
        end else begin
            osc32k_en <= next_o32;
            rtc_run   <= next_rtc;
        end
    end
endmodule // spm_seq
`default_nettype wire

// ==== dv/spm_seq_monitor.sv ====
/* checker for spm_seq: ram freeze, supply switch and mode gating.
   assumes it is bound to spm_seq, with spm_pkg compiled first. */
`timescale 1ns/1ps
`default_nettype none
module spm_seq_monitor
    import spm_pkg::*;
#(
    parameter int unsigned SWITCH_CNT = 4
) (
    // clock and reset
    input wire logic       clk,
    input wire logic       rst_b,
    // supply and reset sources
    input wire logic       reset_input_pin_b,
    input wire logic       low_voltage_detector_ok,
    input wire logic       main_core_supply_good,
    // software controls
    input wire logic       standby_ram_enable_set,
    input wire logic       standby_ram_enable_clear,
    input wire logic [1:0] mode_request,
    input wire logic       mode_wake,
    input wire logic       rtc_use_32k,
    input wire logic       osc32k_present,
    // status and gating outputs
    input wire logic       internal_reset,
    input wire logic       ram_supply_main,
    input wire logic       ram_freeze,
    input wire logic       standby_ram_enable,
    input wire logic       cpu_clk_en,
    input wire logic       periph_clk_en,
    input wire logic       main_osc_en,
    input wire logic       osc32k_en,
    input wire logic       rtc_run
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // running with the ram enabled and a mode asked for
    sequence s_run(logic [1:0] m);
        cpu_clk_en && standby_ram_enable && !internal_reset && mode_request == m;
    endsequence
    AST_FRZ_RST: assert property (internal_reset |-> ram_freeze)
        else $error("ram not frozen in reset");
    AST_FRZ_EN: assert property (!standby_ram_enable |-> ram_freeze)
        else $error("ram thawed without enable");
    AST_EN_RST: assert property (internal_reset [*2] |-> !standby_ram_enable)
        else $error("enable set in reset");
    AST_SUP_RST: assert property (internal_reset [*2] |-> !ram_supply_main)
        else $error("ram on main rail in reset");
    AST_SW_FRZ: assert property ($rose(ram_supply_main) |-> ram_freeze)
        else $error("ram not frozen at supply switch");
    AST_THAW: assert property ($fell(ram_freeze) |-> $past(standby_ram_enable_set))
        else $error("ram thawed without set pulse");
    AST_IDLE: assert property (s_run(MODE_IDLE) |-> ##[1:6] !cpu_clk_en && periph_clk_en && main_osc_en)
        else $error("idle gating wrong");
    AST_PDN: assert property (s_run(MODE_PWRDN) |-> ##[1:6] !cpu_clk_en && !periph_clk_en && rtc_run
        && main_osc_en == !(rtc_use_32k && osc32k_present))
        else $error("power-down gating wrong");
    AST_STBY: assert property (s_run(MODE_STBY) |-> ##[1:6] !cpu_clk_en && !main_osc_en
        && rtc_run == (rtc_use_32k && osc32k_present))
        else $error("stand-by counter gating wrong");
    // main rail gone long enough for the sequencer to sit in hold
    sequence s_rail_off;
        (!main_core_supply_good && $stable(rtc_use_32k) && $stable(osc32k_present)) [*6];
    endsequence
    AST_RAIL_OFF: assert property (s_rail_off |-> !main_osc_en &&
        rtc_run == (rtc_use_32k && osc32k_present))
        else $error("counter or oscillator wrong with main rail off");
    AST_O32: assert property (rtc_run && !main_osc_en |-> osc32k_en)
        else $error("counter running with no oscillator");
endmodule // spm_seq_monitor
bind spm_seq spm_seq_monitor #(.SWITCH_CNT(SWITCH_CNT)) u_mon (.clk(clk), .rst_b(rst_b),
    .reset_input_pin_b(reset_input_pin_b), .low_voltage_detector_ok(low_voltage_detector_ok),
    .main_core_supply_good(main_core_supply_good), .standby_ram_enable_set(standby_ram_enable_set),
    .standby_ram_enable_clear(standby_ram_enable_clear), .mode_wake(mode_wake),
    .rtc_use_32k(rtc_use_32k), .osc32k_present(osc32k_present), .mode_request(mode_request),
    .internal_reset(internal_reset), .ram_supply_main(ram_supply_main), .ram_freeze(ram_freeze),
    .standby_ram_enable(standby_ram_enable), .cpu_clk_en(cpu_clk_en), .rtc_run(rtc_run),
    .periph_clk_en(periph_clk_en), .main_osc_en(main_osc_en), .osc32k_en(osc32k_en));
`default_nettype wire

// ==== dv/spm_supply_model.sv ====
/* supply rail and reset pin model: ramps detector, supply, then pin.
   assumes the bench clock; pwr_on low drops everything at once. */
`timescale 1ns/1ps
`default_nettype none
module spm_supply_model #(
    parameter int RAMP = 20
) (
    input  wire logic clk,
    input  wire logic pwr_on,
    output logic      pin_b,
    output logic      lvd_ok,
    output logic      supply_good
);
    int lvl = 0;
    always @(negedge clk) lvl <= pwr_on ? (lvl < 3 * RAMP ? lvl + 1 : lvl) : 0;
    assign lvd_ok      = lvl >= RAMP;
    assign supply_good = lvl >= 2 * RAMP;
    assign pin_b       = lvl >= 3 * RAMP;
endmodule // spm_supply_model
`default_nettype wire

// ==== dv/spm_seq_tb_top.sv ====
/* bench for spm_seq: stand-by exit, ram enable, mode gating.
   assumes spm_pkg, checker and supply model compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module spm_seq_tb_top
    import spm_pkg::*;
;
    logic        clk = 1'b0, rst_b = 1'b0, pwr_on = 1'b0, en_set = 1'b0, en_clr = 1'b0;
    logic        wake = 1'b0, use32 = 1'b0, pres = 1'b1, e32 = 1'b0;
    logic [1:0]  mode = MODE_RUN;
    wire         pin_b, lvd_ok, sup_ok;
    wire  [8:0]  st;
    logic [17:0] q[$];
    integer      err_total = 0, checked = 0, seed = 32'h6546;
    event        look;
    initial forever #4 clk = ~clk;
    spm_supply_model #(.RAMP(20)) u_sup (.clk(clk), .pwr_on(pwr_on), .pin_b(pin_b),
        .lvd_ok(lvd_ok), .supply_good(sup_ok));
    spm_seq #(.SWITCH_CNT(4)) DUT (.clk(clk), .rst_b(rst_b), .reset_input_pin_b(pin_b),
        .low_voltage_detector_ok(lvd_ok), .main_core_supply_good(sup_ok),
        .standby_ram_enable_set(en_set), .standby_ram_enable_clear(en_clr),
        .mode_request(mode), .mode_wake(wake), .rtc_use_32k(use32), .osc32k_present(pres),
        .internal_reset(st[7]), .ram_supply_main(st[6]), .ram_freeze(st[5]),
        .standby_ram_enable(st[4]), .cpu_clk_en(st[3]), .periph_clk_en(st[2]),
        .main_osc_en(st[1]), .osc32k_en(st[8]), .rtc_run(st[0]));
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask
    task automatic chk(input logic [8:0] m, input logic [8:0] v);
        q.push_back({m, v});
        -> look;
    endtask
    // compares masked status against the oldest note
    initial forever begin
        @(look);
        checked++;
        if ((st & q[0][17:9]) !== q[0][8:0]) begin
            err_total++;
            $display("unexpected status exp %h got %h", q[0][8:0], st & q[0][17:9]);
        end
        void'(q.pop_front());
    end
    task automatic power_up;
        pwr_on = 1'b1;
        tick(20);
        pulse(en_set);
        tick(25);
        chk(9'h0F0, 9'h0A0);
        for (int i = 0; i < 100 && st[3] !== 1'b1; i++) tick(1);
        chk(9'h0F0, 9'h060);
        pulse(en_set);
        tick(2);
        chk(9'h1FF, {e32, 8'h5F});
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        tick(2000);
        err_total++;
        results();
    end
    initial begin
        tick(12);
        rst_b = 1'b1;
        for (int k = 0; k < 4; k++) begin
            use32 = k[0];
            pres  = 1'($random(seed)) | !k[1];
            e32   = use32 & pres;
            power_up();
            pulse(en_clr);
            tick(1);
            chk(9'h030, 9'h020);
            pulse(en_set);
            mode = MODE_IDLE;
            tick(6);
            chk(9'h00F, 9'h007);
            mode = MODE_RUN;
            pulse(wake);
            tick(6);
            chk(9'h1FF, {e32, 8'h5F});
            mode = MODE_PWRDN;
            tick(6);
            chk(9'h10F, {e32, 6'h00, ~e32, 1'b1});
            mode = MODE_RUN;
            pulse(wake);
            tick(6);
            mode = MODE_STBY;
            pulse(en_clr);
            tick(6);
            chk(9'h13F, {e32, 7'h10, e32});
            pwr_on = 1'b0;
            mode = MODE_RUN;
            tick(10);
            chk(9'h1FF, {e32, 4'hA, 3'h0, e32});
            $display("stand-by cycle %0d done", k);
        end
        results();
    end
endmodule // spm_seq_tb_top
`default_nettype wire
